// ### hw/eeeg_pkg.sv
// eee global indirect register constants: byte addresses, offsets, resets, timing
// assumes a byte-wide register port on the switch system clock
package eeeg_pkg;

    // ----------------------------------------
    // direct byte registers
    // ----------------------------------------
    localparam logic [7:0] ADDR_IND_CTRL = 8'h6e;
    localparam logic [7:0] ADDR_IND_OFFSET = 8'h6f;
    localparam logic [7:0] ADDR_IND_DATA = 8'ha0;

    // ----------------------------------------
    // indirect control byte fields
    // ----------------------------------------
    localparam int TABLE_MSB = 7;
    localparam int TABLE_LSB = 5;
    localparam int SET_MSB = 3;
    localparam int SET_LSB = 0;
    localparam logic [2:0] TABLE_EEE = 3'h1;
    localparam logic [3:0] SET_GLOBAL = 4'h0;

    // ----------------------------------------
    // indirect offsets, even byte = bits 15:8
    // ----------------------------------------
    localparam logic [7:0] OFF_WAIT_HI = 8'h32;
    localparam logic [7:0] OFF_WAIT_LO = 8'h33;
    localparam logic [7:0] OFF_DIAG_HI = 8'h34;
    localparam logic [7:0] OFF_DIAG_LO = 8'h35;
    localparam logic [7:0] OFF_MINLPI_HI = 8'h36;
    localparam logic [7:0] OFF_MINLPI_LO = 8'h37;

    // ----------------------------------------
    // reset and fixed values
    // ----------------------------------------
    localparam logic [7:0] RST_IND_CTRL = 8'h00;
    localparam logic [7:0] RST_IND_OFFSET = 8'h00;
    localparam logic [15:0] RST_WAIT_TIME = 16'h0010;
    localparam logic [3:0] RST_NEXT_PAGE = 4'hf;
    localparam logic [7:0] DIAG_HI_FIXED = 8'h68;
    localparam logic [3:0] DIAG_LO_RSVD = 4'h0;
    localparam logic [15:0] MINLPI_FIXED = 16'h0000;
    localparam int NUM_PORTS = 4;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WAIT_UNIT_NS = 1300000;
    localparam int unsigned WAIT_UNIT_CYCLES = WAIT_UNIT_NS / CLK_PERIOD_NS;

endpackage

// ### hw/eeeg_idle_timer.sv
// per-port empty queue timer raising the low-power-idle request
// assumes a shared wait-unit tick pulse from the register block
`timescale 1ns/1ps
module eeeg_idle_timer
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic unit_tick,
    input wire logic eee_enable,
    input wire logic queue_empty,
    input wire logic [15:0] wait_time,
    output logic lpi_request
);

    logic [15:0] empty_units;

    // ----------------------------------------
    // empty time in wait units, saturating
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst || !eee_enable || !queue_empty)
        begin
            empty_units <= 16'h0000;
        end
        else if (unit_tick && empty_units != 16'hffff)
        begin
            empty_units <= empty_units + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || !eee_enable || !queue_empty)
        begin
            lpi_request <= 1'b0;
        end
        else
        begin
            lpi_request <= (empty_units > wait_time);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_req_needs_empty: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(lpi_request) |-> $past(queue_empty) && $past(eee_enable) && $past(empty_units > wait_time))
        else $error("lpi request raised without empty queue beyond wait");

    a_busy_drops_req: assert property (@(posedge clk_sys) disable iff (rst)
        !queue_empty |=> !lpi_request [*2])
        else $error("lpi request held while queue busy");

endmodule // eeeg_idle_timer

// ### hw/eeeg_regs.sv
// eee global indirect registers with per-port idle timers
// assumes byte register strobes are one-cycle pulses on clk_sys
`timescale 1ns/1ps
module eeeg_regs
#(
    parameter int unsigned UNIT_CYCLES = eeeg_pkg::WAIT_UNIT_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic fast_ethernet_mode_eee_en,
    input wire logic [3:0] transmit_queue_empty,
    output logic [3:0] lpi_request,
    output logic [3:0] next_page_enable
);

    logic [7:0] ind_ctrl;
    logic [7:0] ind_offset;
    logic [15:0] wait_time;
    logic [31:0] unit_count;
    logic unit_tick;
    logic global_sel;
    logic data_wr;

    // ----------------------------------------
    // indirect byte read mux
    // ----------------------------------------
    function automatic logic [7:0] global_byte(input logic [7:0] off, input logic [15:0] wt,
                                                input logic [3:0] np);
        logic [7:0] v;
        v = 8'h00;
        case (off)
            eeeg_pkg::OFF_WAIT_HI: v = wt[15:8];
            eeeg_pkg::OFF_WAIT_LO: v = wt[7:0];
            eeeg_pkg::OFF_DIAG_HI: v = eeeg_pkg::DIAG_HI_FIXED;
            eeeg_pkg::OFF_DIAG_LO: v = {eeeg_pkg::DIAG_LO_RSVD, np};
            eeeg_pkg::OFF_MINLPI_HI: v = eeeg_pkg::MINLPI_FIXED[15:8];
            eeeg_pkg::OFF_MINLPI_LO: v = eeeg_pkg::MINLPI_FIXED[7:0];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign global_sel = (ind_ctrl[eeeg_pkg::TABLE_MSB:eeeg_pkg::TABLE_LSB] == eeeg_pkg::TABLE_EEE) &&
                        (ind_ctrl[eeeg_pkg::SET_MSB:eeeg_pkg::SET_LSB] == eeeg_pkg::SET_GLOBAL);
    assign data_wr = reg_wr && reg_addr == eeeg_pkg::ADDR_IND_DATA && global_sel;

    // ----------------------------------------
    // indirect pointer registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ind_ctrl <= eeeg_pkg::RST_IND_CTRL;
        end
        else if (reg_wr && reg_addr == eeeg_pkg::ADDR_IND_CTRL)
        begin
            ind_ctrl <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ind_offset <= eeeg_pkg::RST_IND_OFFSET;
        end
        else if (reg_wr && reg_addr == eeeg_pkg::ADDR_IND_OFFSET)
        begin
            ind_offset <= reg_wdata;
        end
    end

    // ----------------------------------------
    // global eee registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wait_time <= eeeg_pkg::RST_WAIT_TIME;
        end
        else if (data_wr && ind_offset == eeeg_pkg::OFF_WAIT_HI)
        begin
            wait_time[15:8] <= reg_wdata;
        end
        else if (data_wr && ind_offset == eeeg_pkg::OFF_WAIT_LO)
        begin
            wait_time[7:0] <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            next_page_enable <= eeeg_pkg::RST_NEXT_PAGE;
        end
        else if (data_wr && ind_offset == eeeg_pkg::OFF_DIAG_LO)
        begin
            next_page_enable <= reg_wdata[3:0];
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                eeeg_pkg::ADDR_IND_CTRL: reg_rdata <= ind_ctrl;
                eeeg_pkg::ADDR_IND_OFFSET: reg_rdata <= ind_offset;
                eeeg_pkg::ADDR_IND_DATA: reg_rdata <= global_sel ? global_byte(ind_offset, wait_time,
                                                                                 next_page_enable) : 8'h00;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // wait unit prescaler
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst || !fast_ethernet_mode_eee_en || unit_count == UNIT_CYCLES - 1)
        begin
            unit_count <= 32'h0000_0000;
        end
        else
        begin
            unit_count <= unit_count + 32'h0000_0001;
        end
    end

    assign unit_tick = fast_ethernet_mode_eee_en && (unit_count == UNIT_CYCLES - 1);

    // ----------------------------------------
    // per-port timers, one shared wait time
    // ----------------------------------------
    for (genvar p = 0; p < eeeg_pkg::NUM_PORTS; p++)
    begin : g_port
        eeeg_idle_timer u_timer
        (
            .clk_sys(clk_sys),
            .rst(rst),
            .unit_tick(unit_tick),
            .eee_enable(fast_ethernet_mode_eee_en),
            .queue_empty(transmit_queue_empty[p]),
            .wait_time(wait_time),
            .lpi_request(lpi_request[p])
        );
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // reset checks must not be disabled by the reset they watch
    a_wait_reset_val: assert property (@(posedge clk_sys) disable iff (1'b0)
        rst |=> wait_time == eeeg_pkg::RST_WAIT_TIME)
        else $error("wait time reset value wrong");

    a_np_reset_val: assert property (@(posedge clk_sys) disable iff (1'b0)
        rst |=> next_page_enable == eeeg_pkg::RST_NEXT_PAGE)
        else $error("next page enables not set after reset");

    a_wait_lo_write: assert property (data_wr && ind_offset == eeeg_pkg::OFF_WAIT_LO |=>
        wait_time[7:0] == $past(reg_wdata) && $stable(wait_time[15:8]))
        else $error("wait time low byte write wrong");

    a_np_write: assert property (data_wr && ind_offset == eeeg_pkg::OFF_DIAG_LO |=>
        next_page_enable == $past(reg_wdata[3:0]))
        else $error("next page enable write wrong");

    a_other_table: assert property (reg_wr && reg_addr == eeeg_pkg::ADDR_IND_DATA &&
        ind_ctrl[eeeg_pkg::TABLE_MSB:eeeg_pkg::TABLE_LSB] != eeeg_pkg::TABLE_EEE |=>
        $stable(wait_time) && $stable(next_page_enable))
        else $error("write landed with another table selected");

    a_minlpi_zero: assert property (reg_rd && reg_addr == eeeg_pkg::ADDR_IND_DATA &&
        (ind_offset == eeeg_pkg::OFF_MINLPI_HI || ind_offset == eeeg_pkg::OFF_MINLPI_LO)
        |=> reg_rdata == 8'h00)
        else $error("reserved minimum idle register not zero");

    a_wait_hi_read: assert property (reg_rd && reg_addr == eeeg_pkg::ADDR_IND_DATA && global_sel &&
        ind_offset == eeeg_pkg::OFF_WAIT_HI
        |=> reg_rdata == $past(wait_time[15:8]))
        else $error("wait time high byte read wrong");

    a_disabled_idle: assert property (!fast_ethernet_mode_eee_en [*2] |-> lpi_request == 4'h0)
        else $error("lpi request while eee disabled");

    a_shared_tick: assert property (unit_tick |=> unit_count == 32'h0000_0000)
        else $error("prescaler not restarted after unit tick");

endmodule // eeeg_regs

// ### tb/tb_eee_global_indirect_regs.sv
// self-checking bench for the eee global indirect registers and idle timers
// assumes eeeg_pkg and eeeg_regs are compiled first; bench drives every port
`timescale 1ns/1ps
module tb_eee_global_indirect_regs;
    localparam int unsigned UNIT = 4;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic fast_ethernet_mode_eee_en = 1'b0;
    logic [3:0] transmit_queue_empty = 4'h0;
    logic [3:0] lpi_request;
    logic [3:0] next_page_enable;
    int errors = 0;
    int compares = 0;
    int m_wait;
    int m_np;
    logic [7:0] seen;
    logic [7:0] ctrl_bad [4] = '{8'h40, 8'h21, 8'h28, 8'he0};

    eeeg_regs #(.UNIT_CYCLES(UNIT)) uut (
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .fast_ethernet_mode_eee_en(fast_ethernet_mode_eee_en),
        .transmit_queue_empty(transmit_queue_empty),
        .lpi_request(lpi_request),
        .next_page_enable(next_page_enable)
    );

    always #5 clk_sys = ~clk_sys;

    // ----------------------------------------
    // bus tasks and model
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("Error: %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        seen = reg_rdata;
    endtask

    // select the global eee set and a byte offset
    task automatic sel(input logic [7:0] off);
        wr(eeeg_pkg::ADDR_IND_CTRL, {eeeg_pkg::TABLE_EEE, 1'b0, eeeg_pkg::SET_GLOBAL});
        wr(eeeg_pkg::ADDR_IND_OFFSET, off);
    endtask

    function automatic logic [7:0] exp_byte(input int off);
        case (off)
            8'h32: return 8'(m_wait >> 8);
            8'h33: return 8'(m_wait);
            8'h34: return 8'h68;
            8'h35: return 8'(m_np);
            default: return 8'h00;
        endcase
    endfunction

    task automatic read_all;
        for (int off = 8'h32; off <= 8'h38; off++)
        begin
            sel(8'(off));
            rd(eeeg_pkg::ADDR_IND_DATA);
            check("indirect byte", seen, exp_byte(off));
        end
        check("next_page_enable", {4'h0, next_page_enable}, 8'(m_np));
    endtask

    task automatic run_timer(input int w, input logic [3:0] m);
        sel(8'h32);
        wr(eeeg_pkg::ADDR_IND_DATA, 8'(w >> 8));
        sel(8'h33);
        wr(eeeg_pkg::ADDR_IND_DATA, 8'(w));
        m_wait = w;
        @(posedge clk_sys);
        transmit_queue_empty <= m;
        for (int n = 1; n <= (w + 1) * UNIT + 3; n++)
        begin
            @(posedge clk_sys);
            #1;
            check("lpi idle ports", {4'h0, lpi_request & ~m}, 8'h00);
            if (n == w * UNIT + 1)
                check("lpi early", {4'h0, lpi_request}, 8'h00);
        end
        check("lpi_request", {4'h0, lpi_request}, {4'h0, m});
        @(posedge clk_sys);
        transmit_queue_empty <= 4'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("lpi drop", {4'h0, lpi_request}, 8'h00);
    endtask

    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        logic [31:0] r;
        void'($urandom(32'h1043e91d));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        m_wait = 16'h0010;
        m_np = 4'hf;
        read_all;
        $display("test reset values done");
        repeat (5)
        begin
            for (int off = 8'h32; off <= 8'h37; off++)
            begin
                r = $urandom;
                sel(8'(off));
                wr(eeeg_pkg::ADDR_IND_DATA, r[7:0]);
                if (off == 8'h32)
                    m_wait = {r[7:0], m_wait[7:0]};
                if (off == 8'h33)
                    m_wait = {m_wait[15:8], r[7:0]};
                if (off == 8'h35)
                    m_np = r[3:0];
            end
            read_all;
        end
        $display("test random access done");
        foreach (ctrl_bad[i])
        begin
            wr(eeeg_pkg::ADDR_IND_CTRL, ctrl_bad[i]);
            wr(eeeg_pkg::ADDR_IND_OFFSET, 8'h33);
            wr(eeeg_pkg::ADDR_IND_DATA, ~exp_byte(8'h33));
            rd(eeeg_pkg::ADDR_IND_DATA);
            check("wrong table read", seen, 8'h00);
        end
        wr(8'h55, 8'ha5);
        rd(8'h55);
        check("unmapped read", seen, 8'h00);
        read_all;
        $display("test refused access done");
        @(posedge clk_sys);
        fast_ethernet_mode_eee_en <= 1'b1;
        repeat (4)
            run_timer($urandom_range(3, 0), 4'($urandom_range(15, 1)));
        $display("test idle timer done");
        @(posedge clk_sys);
        fast_ethernet_mode_eee_en <= 1'b0;
        transmit_queue_empty <= 4'hf;
        repeat (3 * UNIT + 8) @(posedge clk_sys);
        #1;
        check("lpi disabled", {4'h0, lpi_request}, 8'h00);
        @(posedge clk_sys);
        fast_ethernet_mode_eee_en <= 1'b1;
        // prescaler restarts from zero, so the wait is counted from here
        repeat ((m_wait + 1) * UNIT) @(posedge clk_sys);
        #1;
        check("lpi enable early", {4'h0, lpi_request}, 8'h00);
        repeat (3) @(posedge clk_sys);
        #1;
        check("lpi enabled", {4'h0, lpi_request}, 8'h0f);
        $display("test eee enable done");
        final_report;
    end

    initial
    begin
        #400000;
        errors++;
        final_report;
    end
endmodule // tb_eee_global_indirect_regs
